// ---- common/dbs_cfg.svh ----
/*
 Constants of the two-word burst DDR SRAM port: widths, lane size,
 read slot count and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DBS_CFG_SVH
`define DBS_CFG_SVH

`define DBS_ADDR_W      20
`define DBS_DATA_W      18
`define DBS_LANE_W      9
`define DBS_NUM_SLOTS   2
`define DBS_OE_RST      1'b0
`define DBS_SINGLE_RST  1'b0
`define DBS_RD_WAIT_MAX 40

`endif

// ---- common/dbs_pkg.sv ----
/*
 Types shared by the SRAM port: the synchronised control pin bundle
 and the read slot and write collect state enumerations.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dbs_pkg;

    typedef struct packed {
        logic mpos;
        logic mneg;
        logic opos;
        logic oneg;
        logic load_n;
        logic rw_sel;
        logic dll_dis_n;
    } dbs_ctrl_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_WAIT,
        RD_FIRST,
        RD_SECOND
    } dbs_rd_state_t;

    typedef enum logic {
        WR_IDLE,
        WR_BEAT1
    } dbs_wr_state_t;

endpackage

// ---- hw/dbs_lane_merge.sv ----
/*
 Byte lane merge: each lane takes the new word where its enable is
 set and keeps the old word elsewhere.
 Assumes DATA_W is a whole multiple of LANE_W.
*/
`timescale 1ns/100ps
module dbs_lane_merge #(
    parameter int DATA_W = 18,
    parameter int LANE_W = 9
) (
    // Words
    input  wire logic [DATA_W-1:0]        old_in,
    input  wire logic [DATA_W-1:0]        new_in,
    // Lane enables, active high
    input  wire logic [DATA_W/LANE_W-1:0] wr_en_in,
    // Result
    output logic      [DATA_W-1:0]        merged_out
);
    genvar g;
    generate
        for (g = 0; g < DATA_W / LANE_W; g++) begin : g_lane
            assign merged_out[g*LANE_W +: LANE_W] = wr_en_in[g] ?
                new_in[g*LANE_W +: LANE_W] : old_in[g*LANE_W +: LANE_W];
        end
    endgenerate
endmodule

// ---- hw/dbs_sram_port.sv ----
/*
 Two-word burst DDR SRAM port: pin synchronisers, command decode,
 write beat capture with posted write, flip-flop array, read slots
 and common data pin drive.
 Assumes all pins are asynchronous to clock_in and the pin clocks run
 well below a quarter of clock_in; output clocks aligned with or
 leading the master clocks.
*/
// Summary of operation
// - write command, beats at next rise pair
// - read words at neg t+1, pos t+2
// - deselected with high Z after power-up
// - second word address has LSB inverted
// - narrow width two active-low byte selects
// - narrow width no selects writes nothing
// - wide width all selects write whole word
// - wide width four active-low byte selects
// - wide width no selects writes nothing
// - write data taken on both master rises
// - read data on output pair, else master
// - posted write committed later, reads bypass
// - output pair high at power-on selects single
// - DLL disabled gives one cycle latency
`timescale 1ns/100ps
`include "dbs_cfg.svh"
module dbs_sram_port
    import dbs_pkg::*;
#(
    parameter int ADDR_W = `DBS_ADDR_W,
    parameter int DATA_W = `DBS_DATA_W
) (
    // Clock and reset
    input  wire logic                         clock_in,
    input  wire logic                         rst_in,
    // Input clock pair
    input  wire logic                         master_pos_edge_in,
    input  wire logic                         master_neg_edge_in,
    // Output clock pair
    input  wire logic                         output_timing_pos_in,
    input  wire logic                         output_timing_neg_in,
    // Command, selects and strap
    input  wire logic                         load_n_in,
    input  wire logic                         read_write_sel_in,
    input  wire logic [ADDR_W-1:0]            addr_in,
    input  wire logic [DATA_W/`DBS_LANE_W-1:0] byte_write_sel_n_in,
    input  wire logic                         dll_disable_n_in,
    // Common data pins
    input  wire logic [DATA_W-1:0]            dq_in,
    output logic      [DATA_W-1:0]            dq_out,
    output logic                              dq_oe_out
);
    localparam int NB = DATA_W / `DBS_LANE_W;
    localparam int NS = `DBS_NUM_SLOTS;
    localparam int IW = (NS > 1) ? $clog2(NS) : 1;
    localparam int RD_WAIT_MAX = `DBS_RD_WAIT_MAX;

    dbs_ctrl_t            ctl_s1_r;
    dbs_ctrl_t            ctl_s2_r;
    dbs_ctrl_t            ctl_s3_r;
    logic [ADDR_W-1:0]    addr_s1_r;
    logic [ADDR_W-1:0]    addr_s2_r;
    logic [NB-1:0]        wsel_s1_r;
    logic [NB-1:0]        wsel_s2_r;
    logic [DATA_W-1:0]    din_s1_r;
    logic [DATA_W-1:0]    din_s2_r;
    logic                 pos_rise;
    logic                 neg_rise;
    logic                 out_pos;
    logic                 out_neg;
    logic                 dll_on;
    logic                 strap_done_r;
    logic                 single_r;
    logic                 cmd_rd;
    logic                 cmd_wr;
    logic                 wq_valid_r;
    logic [ADDR_W-1:0]    wq_addr_r;
    dbs_wr_state_t        col_st_r;
    logic [ADDR_W-1:0]    col_addr_r;
    logic [DATA_W-1:0]    col_d0_r;
    logic [NB-1:0]        col_be0_r;
    logic                 col_done;
    logic                 post_valid_r;
    logic [ADDR_W-1:0]    post_addr_r;
    logic [ADDR_W-1:0]    post_pair_addr;
    logic [DATA_W-1:0]    post_d0_r;
    logic [DATA_W-1:0]    post_d1_r;
    logic [NB-1:0]        post_be0_r;
    logic [NB-1:0]        post_be1_r;
    logic                 commit;
    logic [DATA_W-1:0]    mem_r [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]    cm_old0;
    logic [DATA_W-1:0]    cm_new0;
    logic [DATA_W-1:0]    cm_new1;
    dbs_rd_state_t        slot_st_r [NS];
    logic [ADDR_W-1:0]    slot_addr_r [NS];
    logic                 fire;
    logic                 fire_second;
    logic [ADDR_W-1:0]    fire_base;
    logic [ADDR_W-1:0]    rd_addr;
    logic                 free_ok;
    logic [IW-1:0]        free_idx;
    logic                 post_hit;
    logic                 post_sel;
    logic [DATA_W-1:0]    post_word;
    logic [NB-1:0]        post_en;
    logic [NB-1:0]        col_en;
    logic [DATA_W-1:0]    rd_post;
    logic [DATA_W-1:0]    rd_word;
    logic                 rd_seen_r;

    // Two-stage pin synchronisers, third stage for edge finding
    always_ff @(posedge clock_in) begin
        ctl_s1_r  <= '{mpos: master_pos_edge_in, mneg: master_neg_edge_in,
                       opos: output_timing_pos_in, oneg: output_timing_neg_in,
                       load_n: load_n_in, rw_sel: read_write_sel_in,
                       dll_dis_n: dll_disable_n_in};
        ctl_s2_r  <= ctl_s1_r;
        ctl_s3_r  <= ctl_s2_r;
        addr_s1_r <= addr_in;
        addr_s2_r <= addr_s1_r;
        wsel_s1_r <= byte_write_sel_n_in;
        wsel_s2_r <= wsel_s1_r;
        din_s1_r  <= dq_in;
        din_s2_r  <= din_s1_r;
    end

    assign pos_rise = ctl_s2_r.mpos & ~ctl_s3_r.mpos;
    assign neg_rise = ctl_s2_r.mneg & ~ctl_s3_r.mneg;
    assign out_pos  = single_r ? pos_rise : (ctl_s2_r.opos & ~ctl_s3_r.opos);
    assign out_neg  = single_r ? neg_rise : (ctl_s2_r.oneg & ~ctl_s3_r.oneg);
    assign dll_on   = ctl_s2_r.dll_dis_n;

    // Clock mode strap caught once after reset release
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            strap_done_r <= 1'b0;
            single_r     <= `DBS_SINGLE_RST;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            single_r     <= ctl_s2_r.opos & ctl_s2_r.oneg;
        end
    end

    // Commands only on master positive rises with load low
    assign cmd_rd = pos_rise & ~ctl_s2_r.load_n & ctl_s2_r.rw_sel;
    assign cmd_wr = pos_rise & ~ctl_s2_r.load_n & ~ctl_s2_r.rw_sel;

    // Write address waits one master cycle for its first beat
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wq_valid_r <= 1'b0;
            wq_addr_r  <= '0;
        end else if (pos_rise) begin
            wq_valid_r <= cmd_wr;
            if (cmd_wr) begin
                wq_addr_r <= addr_s2_r;
            end
        end
    end

    // First beat on master positive rise of t+1
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            col_st_r   <= WR_IDLE;
            col_addr_r <= '0;
            col_d0_r   <= '0;
            col_be0_r  <= '0;
        end else if (pos_rise && wq_valid_r) begin
            col_st_r   <= WR_BEAT1;
            col_addr_r <= wq_addr_r;
            col_d0_r   <= din_s2_r;
            col_be0_r  <= ~wsel_s2_r;
        end else if (col_done) begin
            col_st_r   <= WR_IDLE;
        end
    end

    assign col_done = neg_rise && (col_st_r == WR_BEAT1);
    assign commit   = col_done && post_valid_r;

    // Second beat on master negative rise; whole burst becomes posted
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            post_valid_r <= 1'b0;
            post_addr_r  <= '0;
            post_d0_r    <= '0;
            post_d1_r    <= '0;
            post_be0_r   <= '0;
            post_be1_r   <= '0;
        end else if (col_done) begin
            post_valid_r <= 1'b1;
            post_addr_r  <= col_addr_r;
            post_d0_r    <= col_d0_r;
            post_be0_r   <= col_be0_r;
            post_d1_r    <= din_s2_r;
            post_be1_r   <= ~wsel_s2_r;
        end
    end

    // Previous posted burst goes to the array when the next one lands
    assign post_pair_addr = {post_addr_r[ADDR_W-1:1], ~post_addr_r[0]};
    assign cm_old0        = mem_r[post_addr_r];

    dbs_lane_merge #(.DATA_W(DATA_W), .LANE_W(`DBS_LANE_W)) u_commit0 (
        .old_in     (cm_old0),
        .new_in     (post_d0_r),
        .wr_en_in   (post_be0_r),
        .merged_out (cm_new0)
    );

    dbs_lane_merge #(.DATA_W(DATA_W), .LANE_W(`DBS_LANE_W)) u_commit1 (
        .old_in     (mem_r[post_pair_addr]),
        .new_in     (post_d1_r),
        .wr_en_in   (post_be1_r),
        .merged_out (cm_new1)
    );

    always_ff @(posedge clock_in) begin
        if (commit) begin
            mem_r[post_addr_r]    <= cm_new0;
            mem_r[post_pair_addr] <= cm_new1;
        end
    end

    // Lowest idle read slot; one sending its last word counts as idle
    always_comb begin
        free_ok  = 1'b0;
        free_idx = '0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (slot_st_r[i] == RD_IDLE ||
                (slot_st_r[i] == RD_SECOND && (dll_on ? out_pos : out_neg))) begin
                free_ok  = 1'b1;
                free_idx = IW'(i);
            end
        end
    end

    // Read slots step on output clock rises
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < NS; i++) begin
                slot_st_r[i]   <= RD_IDLE;
                slot_addr_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NS; i++) begin
                case (slot_st_r[i])
                    RD_IDLE: begin
                        if (cmd_rd && free_ok && free_idx == IW'(i)) begin
                            slot_st_r[i]   <= RD_WAIT;
                            slot_addr_r[i] <= addr_s2_r;
                        end
                    end
                    RD_WAIT: begin
                        if (out_pos) begin
                            slot_st_r[i] <= dll_on ? RD_FIRST : RD_SECOND;
                        end
                    end
                    RD_FIRST: begin
                        if (out_neg) begin
                            slot_st_r[i] <= RD_SECOND;
                        end
                    end
                    RD_SECOND: begin
                        if (dll_on ? out_pos : out_neg) begin
                            // Seamless reads reuse the slot at once
                            if (cmd_rd && free_ok && free_idx == IW'(i)) begin
                                slot_st_r[i]   <= RD_WAIT;
                                slot_addr_r[i] <= addr_s2_r;
                            end else begin
                                slot_st_r[i] <= RD_IDLE;
                            end
                        end
                    end
                    default: begin
                        slot_st_r[i] <= RD_IDLE;
                    end
                endcase
            end
        end
    end

    // Word to launch on this output rise
    always_comb begin
        fire        = 1'b0;
        fire_second = 1'b0;
        fire_base   = '0;
        rd_addr     = '0;
        for (int i = 0; i < NS; i++) begin
            if ((slot_st_r[i] == RD_FIRST && out_neg) ||
                (slot_st_r[i] == RD_WAIT && !dll_on && out_pos)) begin
                fire      = 1'b1;
                fire_base = slot_addr_r[i];
                rd_addr   = slot_addr_r[i];
            end else if (slot_st_r[i] == RD_SECOND && (dll_on ? out_pos : out_neg)) begin
                fire        = 1'b1;
                fire_second = 1'b1;
                fire_base   = slot_addr_r[i];
                rd_addr     = {slot_addr_r[i][ADDR_W-1:1], ~slot_addr_r[i][0]};
            end
        end
    end

    // Newest data: array, then posted burst, then a half-taken burst
    assign post_sel  = rd_addr[0] ^ post_addr_r[0];
    assign post_hit  = post_valid_r && (rd_addr[ADDR_W-1:1] == post_addr_r[ADDR_W-1:1]);
    assign post_word = post_sel ? post_d1_r : post_d0_r;
    assign post_en   = post_hit ? (post_sel ? post_be1_r : post_be0_r) : '0;
    assign col_en    = (col_st_r == WR_BEAT1 && rd_addr == col_addr_r) ? col_be0_r : '0;

    dbs_lane_merge #(.DATA_W(DATA_W), .LANE_W(`DBS_LANE_W)) u_rd_post (
        .old_in     (mem_r[rd_addr]),
        .new_in     (post_word),
        .wr_en_in   (post_en),
        .merged_out (rd_post)
    );

    dbs_lane_merge #(.DATA_W(DATA_W), .LANE_W(`DBS_LANE_W)) u_rd_col (
        .old_in     (rd_post),
        .new_in     (col_d0_r),
        .wr_en_in   (col_en),
        .merged_out (rd_word)
    );

    // Data pin drive; released on any output rise with nothing to send
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dq_out    <= '0;
            dq_oe_out <= `DBS_OE_RST;
        end else if (fire) begin
            dq_out    <= rd_word;
            dq_oe_out <= 1'b1;
        end else if (out_pos || out_neg) begin
            dq_oe_out <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rd_seen_r <= 1'b0;
        end else if (cmd_rd) begin
            rd_seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_wr_cmd;
        cmd_wr;
    endsequence

    sequence s_beat0;
        pos_rise && wq_valid_r;
    endsequence

    sequence s_rd_cmd;
        cmd_rd && free_ok;
    endsequence

    wr_queue_a: assert property (s_wr_cmd |=> wq_valid_r && wq_addr_r == $past(addr_s2_r))
        else $error("write command address not queued");
    wr_beat0_a: assert property (s_beat0 |=> col_st_r == WR_BEAT1 && col_d0_r == $past(din_s2_r))
        else $error("first write beat not taken");
    beat0_sel_a: assert property (s_beat0 |=> col_be0_r == ~$past(wsel_s2_r))
        else $error("first beat selects wrong");
    beat1_sel_a: assert property (col_done |=> post_d1_r == $past(din_s2_r)
                                  && post_be1_r == ~$past(wsel_s2_r))
        else $error("second beat data or selects wrong");
    masked_hold_a: assert property (commit && post_be0_r == '0
                                    |=> mem_r[$past(post_addr_r)] == $past(cm_old0))
        else $error("deselected beat changed the array");
    full_write_a: assert property (commit && post_be0_r == '1
                                   |=> mem_r[$past(post_addr_r)] == $past(post_d0_r))
        else $error("fully selected beat not written");
    burst_pair_a: assert property (fire |-> rd_addr[ADDR_W-1:1] == fire_base[ADDR_W-1:1]
                                   && rd_addr[0] == (fire_base[0] ^ fire_second))
        else $error("burst address order wrong");
    bypass_a: assert property (fire && post_hit && post_en == '1 && col_en == '0
                               |=> dq_out == $past(post_word))
        else $error("read missed newest posted data");
    nop_hiz_a: assert property ((out_pos || out_neg) && !fire |=> !dq_oe_out)
        else $error("pins driven with nothing to send");
    power_up_a: assert property (!rd_seen_r |-> !dq_oe_out)
        else $error("pins driven before any read");
    clock_stop_a: assert property (!(out_pos || out_neg)
                                   |=> $stable(dq_out) && $stable(dq_oe_out))
        else $error("outputs moved without an output rise");
    strap_hold_a: assert property (strap_done_r |=> $stable(single_r))
        else $error("clock mode changed in operation");
    rd_launch_a: assert property (s_rd_cmd |-> ##[1:RD_WAIT_MAX] dq_oe_out)
        else $error("read data never launched");
endmodule

// ---- verif/dbs_ctrl_model.sv ----
/*
 Memory controller model: link clock frames of queued commands and
 write beats; samples the read data pins twice per link cycle.
 Assumes clock_in at 125 MHz; one link cycle is ten clock_in cycles.
*/
`timescale 1ns/100ps
module dbs_ctrl_model #(
    parameter int ADDR_W = 6,
    parameter int DATA_W = 36
) (
    // System clock
    input  wire logic              clock_in,
    // Clock pairs
    output logic                   master_pos_edge_out,
    output logic                   master_neg_edge_out,
    output logic                   output_timing_pos_out,
    output logic                   output_timing_neg_out,
    // Command and write data
    output logic                   load_n_out,
    output logic                   read_write_sel_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [DATA_W/9-1:0]    byte_write_sel_n_out,
    output logic [DATA_W-1:0]      wr_data_out,
    // Read data
    input  wire logic [DATA_W-1:0] rd_data_in,
    input  wire logic              rd_oe_in
);
    localparam int NB = DATA_W / 9;
    typedef struct {
        logic [1:0]        op;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
        logic [NB-1:0]     s0;
        logic [NB-1:0]     s1;
    } dbs_cmd_t;
    dbs_cmd_t          cq[$];
    logic [DATA_W-1:0] dq_s[$];
    logic              oe_s[$];
    logic              single = 1'b0;

    initial begin
        {master_pos_edge_out, master_neg_edge_out} = 2'b00;
        {output_timing_pos_out, output_timing_neg_out} = 2'b00;
        {load_n_out, read_write_sel_out, addr_out} = '1;
        {byte_write_sel_n_out, wr_data_out} = '1;
    end

    // Op 0 idle, 1 write, 2 read
    task automatic push(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d0, d1, input logic [NB-1:0] s0, s1);
        cq.push_back('{op, a, d0, d1, s0, s1});
    endtask

    task automatic set_single(input logic s);
        single = s;
        {output_timing_pos_out, output_timing_neg_out} = {s, s};
    endtask

    task automatic set_cmd(input int c);
        logic [1:0] op;
        op = (c < cq.size()) ? cq[c].op : 2'd0;
        load_n_out = (op == 2'd0);
        read_write_sel_out = (op == 2'd0) ? ~read_write_sel_out : op[1];
        addr_out = (op == 2'd0) ? ~addr_out : cq[c].a;
    endtask

    // Idle data lines show the inverse of the last value
    task automatic set_beat(input int c, input logic second);
        if (c >= 0 && c < cq.size() && cq[c].op == 2'd1) begin
            wr_data_out = second ? cq[c].d1 : cq[c].d0;
            byte_write_sel_n_out = second ? cq[c].s1 : cq[c].s0;
        end else begin
            wr_data_out = ~wr_data_out;
            byte_write_sel_n_out = '0;
        end
    endtask

    task automatic run(input int trail);
        int n;
        repeat (trail) push(2'd0, '0, '0, '0, '0, '0);
        n = cq.size();
        dq_s.delete();
        oe_s.delete();
        set_cmd(0);
        repeat (3) @(posedge clock_in);
        #1;
        for (int c = 0; c < n; c++) begin
            for (int p = 0; p < 10; p++) begin
                if (p == 0) begin
                    {master_pos_edge_out, master_neg_edge_out} = 2'b10;
                    {output_timing_pos_out, output_timing_neg_out} = {1'b1, single};
                end
                if (p == 5) begin
                    {master_pos_edge_out, master_neg_edge_out} = 2'b01;
                    {output_timing_pos_out, output_timing_neg_out} = {single, 1'b1};
                end
                if (p == 2 || p == 7) begin
                    dq_s.push_back(rd_data_in);
                    oe_s.push_back(rd_oe_in);
                end
                if (p == 2) set_beat(c - 1, 1'b1);
                if (p == 7) begin
                    set_beat(c, 1'b0);
                    set_cmd(c + 1);
                end
                @(posedge clock_in);
                #1;
            end
        end
        // Park each pair at equal levels
        master_neg_edge_out = 1'b0;
        output_timing_neg_out = single;
        cq.delete();
    endtask

    // Controls wander while the clocks stand still
    task automatic poke();
        {load_n_out, read_write_sel_out} = 2'b01;
        addr_out = ~addr_out;
        repeat (8) @(posedge clock_in);
        #1;
        load_n_out = 1'b1;
    endtask
endmodule

// ---- verif/tb.sv ----
/*
 Self-checking bench for the wide SRAM port: command frames through the
 controller model, expected words from a memory model of the bench.
 Assumes the port and the controller model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    localparam int AW = 6;
    localparam int DW = 36;
    localparam int NB = DW / 9;
    logic          clock_in;
    logic          rst_in;
    logic          mpos, mneg, opos, oneg, load_n, rw, dll_n, dq_oe;
    logic [AW-1:0] addr;
    logic [NB-1:0] wsel_n;
    logic [DW-1:0] dq_w, dq_r;
    int            fail_count = 0;
    int            checks = 0;
    int            cyc = 0;
    int            lat = 4;
    logic [DW-1:0] mem [0:63];
    logic [DW-1:0] e_dq [0:255];
    logic          e_oe [0:255];

    dbs_sram_port #(.ADDR_W(AW), .DATA_W(DW)) u_dbs_sram_port (
        .clock_in(clock_in), .rst_in(rst_in),
        .master_pos_edge_in(mpos), .master_neg_edge_in(mneg),
        .output_timing_pos_in(opos), .output_timing_neg_in(oneg),
        .load_n_in(load_n), .read_write_sel_in(rw), .addr_in(addr),
        .byte_write_sel_n_in(wsel_n), .dll_disable_n_in(dll_n),
        .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(dq_oe));

    dbs_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) m_ctrl (
        .clock_in(clock_in),
        .master_pos_edge_out(mpos), .master_neg_edge_out(mneg),
        .output_timing_pos_out(opos), .output_timing_neg_out(oneg),
        .load_n_out(load_n), .read_write_sel_out(rw), .addr_out(addr),
        .byte_write_sel_n_out(wsel_n), .wr_data_out(dq_w),
        .rd_data_in(dq_r), .rd_oe_in(dq_oe));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // Run is just under a thousand cycles
    initial begin
        #200000;
        fail_count++;
        final_report();
    end

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n, input logic [NB-1:0] s);
        for (int l = 0; l < NB; l++)
            if (!s[l]) o[l*9 +: 9] = n[l*9 +: 9];
        return o;
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                      input logic [NB-1:0] s0, s1);
        mem[a] = merge(mem[a], d0, s0);
        mem[{a[AW-1:1], ~a[0]}] = merge(mem[{a[AW-1:1], ~a[0]}], d1, s1);
        m_ctrl.push(2'd1, a, d0, d1, s0, s1);
        cyc++;
    endtask

    // Word order A then A with its low bit inverted
    task automatic rd(input logic [AW-1:0] a);
        e_dq[2*cyc+lat] = mem[a];
        e_dq[2*cyc+lat+1] = mem[{a[AW-1:1], ~a[0]}];
        {e_oe[2*cyc+lat], e_oe[2*cyc+lat+1]} = 2'b11;
        m_ctrl.push(2'd2, a, '0, '0, '0, '0);
        cyc++;
    endtask

    task automatic nop();
        m_ctrl.push(2'd0, '0, '0, '0, '0, '0);
        cyc++;
    endtask

    task automatic go(input int trail);
        m_ctrl.run(trail);
        for (int i = 0; i < m_ctrl.oe_s.size(); i++) begin
            `CHK(m_ctrl.oe_s[i], e_oe[i])
            if (e_oe[i] === 1'b1) `CHK(m_ctrl.dq_s[i], e_dq[i])
        end
        e_oe = '{default: 1'b0};
        cyc = 0;
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        repeat (16) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
    endtask

    task automatic t_idle();
        `CHK(dq_oe, 1'b0)
        repeat (4) nop();
        go(0);
    endtask

    // Even and odd bursts, seamless reads, posted write and bypass
    task automatic t_burst();
        wr(6'd4, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
        wr(6'd7, 36'ha_aaaa_5555, 36'h5_5555_aaaa, 4'h0, 4'h0);
        rd(6'd4);
        rd(6'd7);
        rd(6'd5);
        nop();
        wr(6'd8, 36'h0_1111_2222, 36'h3_3333_4444, 4'h0, 4'h0);
        wr(6'd8, 36'hf_ffff_ffff, 36'he_eeee_eeee, 4'b1010, 4'b0101);
        rd(6'd8);
        rd(6'd9);
        nop();
        wr(6'd20, 36'hc_0c0c_0c0c, 36'h3_0303_0303, 4'h0, 4'h0);
        rd(6'd8);
        rd(6'd20);
        go(3);
    endtask

    // Every select pattern on beat one, its complement on beat two
    task automatic t_bytes();
        for (int p = 0; p < 16; p++)
            wr(6'(32+2*p), 36'h1_0203_0405 * p, 36'h0, 4'h0, 4'h0);
        for (int p = 0; p < 16; p++)
            wr(6'(32+2*p), 36'h5_a5a5_a5a5, ~36'h0, 4'(p+1), ~4'(p+1));
        nop();
        for (int p = 0; p < 16; p++)
            rd(6'(32+2*p));
        go(3);
    endtask

    task automatic t_dll_off();
        dll_n = 1'b0;
        lat = 3;
        repeat (8) @(posedge clock_in);
        #1;
        rd(6'd4);
        rd(6'd20);
        go(3);
        dll_n = 1'b1;
        lat = 4;
    endtask

    // Clocks stop between the two words of a read
    task automatic t_stop();
        rd(6'd7);
        go(1);
        repeat (20) @(posedge clock_in);
        #1;
        `CHK(dq_r, mem[7])
        `CHK(dq_oe, 1'b1)
        m_ctrl.poke();
        {e_dq[0], e_dq[1]} = {mem[7], mem[6]};
        {e_oe[0], e_oe[1]} = 2'b11;
        go(2);
    endtask

    // Output pair held high through reset: master pair times reads
    task automatic t_single();
        m_ctrl.set_single(1'b1);
        do_reset();
        `CHK(dq_oe, 1'b0)
        wr(6'd12, 36'h3_c3c3_c3c3, 36'h6_9696_9696, 4'h0, 4'h0);
        rd(6'd12);
        nop();
        rd(6'd13);
        go(3);
    endtask

    initial begin
        rst_in = 1'b1;
        dll_n = 1'b1;
        e_oe = '{default: 1'b0};
        do_reset();
        t_idle();
        t_burst();
        t_bytes();
        t_dll_off();
        t_stop();
        t_single();
        final_report();
    end
endmodule
